// [hw/hotswap_monitor_pkg.sv]
// Constants, register map and link states for the monitor register bank.
// Assumes a byte-level bus front end outside; strap pins sensed as two-bit codes.
package hotswap_monitor_pkg;
  // ---------------------------------------------------------------
  // Register map (index = low three bits of the command byte)
  // ---------------------------------------------------------------
  localparam int IDX_W = 3;
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_ALERT = 3'h1;
  localparam logic [2:0] IDX_STATUS = 3'h2;
  localparam logic [2:0] IDX_FAULT = 3'h3;
  localparam logic [2:0] IDX_SENSE = 3'h4;
  localparam logic [2:0] IDX_SOURCE = 3'h5;
  localparam logic [2:0] IDX_AUX = 3'h6;
  localparam logic [2:0] IDX_AUX_ALIAS = 3'h7;
  localparam int NUM_ADC = 3;
  // ---------------------------------------------------------------
  // Field positions, masks and reset values
  // ---------------------------------------------------------------
  localparam int PIN_FN_LO = 6;
  localparam int PIN_FN_HI = 7;
  localparam int TEST_MODE_POS = 5;
  localparam int BCAST_EN_POS = 4;
  localparam int SWITCH_ON_POS = 3;
  localparam int OC_RETRY_POS = 2;
  localparam int UV_RETRY_POS = 1;
  localparam int OV_RETRY_POS = 0;
  localparam int PIN_DATA_POS = 6;
  localparam int PWR_BAD_POS = 3;
  localparam int NUM_FAULT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h13;
  localparam logic [7:0] ALERT_RESET = 8'h00;
  localparam logic [7:0] ALERT_MASK = 8'h7f;
  localparam logic [7:0] FAULT_MASK = 8'h3f;
  localparam logic [7:0] ADC_RESET = 8'h00;
  // Pin function codes as {bit7, bit6}
  localparam logic [1:0] FN_PWR_GOOD = 2'h0;
  localparam logic [1:0] FN_PWR_BAD = 2'h2;
  localparam logic [1:0] FN_OUTPUT = 2'h1;
  // ---------------------------------------------------------------
  // Bus addresses and strap handling
  // ---------------------------------------------------------------
  localparam logic [1:0] ADDR_FIXED = 2'h2;
  localparam logic [6:0] BCAST_ADDR = 7'h5f;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [1:0] STRAP_L = 2'h0;
  localparam logic [1:0] STRAP_H = 2'h1;
  localparam logic [3:0] STRAP_SETTLE = 4'h3;
  // Strap index t2*9 + t1*3 + t0 with L=0, H=1, open=2
  localparam logic [4:0] STRAP_TABLE [27] = '{
    5'd4, 5'd7, 5'd6, 5'd24, 5'd5, 5'd1, 5'd0, 5'd3, 5'd2,
    5'd20, 5'd23, 5'd22, 5'd26, 5'd21, 5'd17, 5'd16, 5'd19, 5'd18,
    5'd12, 5'd15, 5'd14, 5'd25, 5'd13, 5'd9, 5'd8, 5'd11, 5'd10};
  // Two-bit pin code to trit; any code other than L or H reads open
  function automatic logic [4:0] trit(input logic [1:0] c);
    trit = (c == STRAP_L) ? 5'd0 : ((c == STRAP_H) ? 5'd1 : 5'd2);
  endfunction
  function automatic logic [4:0] strap_decode(input logic [5:0] s);
    logic [4:0] idx;
    idx = 5'(trit(s[5:4]) * 5'd9 + trit(s[3:2]) * 5'd3 + trit(s[1:0]));
    strap_decode = STRAP_TABLE[idx];
  endfunction
  // ---------------------------------------------------------------
  // Link-side transaction states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_ADDR = 3'b001,
    L_CMD = 3'b010,
    L_DATA = 3'b011,
    L_DISCARD = 3'b100,
    L_READ = 3'b101,
    L_ARA = 3'b110,
    L_NOMATCH = 3'b111
  } link_state_t;
endpackage

// [hw/cdc_word_handshake.sv]
// Toggle handshake moving one word from a source clock to a destination clock.
// Assumes the source waits for busy low; a request while busy is dropped.
module cdc_word_handshake
  import hotswap_monitor_pkg::*;
#(
  parameter int W = 8
)(
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_valid,
  input wire logic [W-1:0] src_data,
  output logic src_busy,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic dst_valid,
  output logic [W-1:0] dst_data
);
  logic req_q, ack_s1_q, ack_s2_q;
  logic [W-1:0] hold_q;
  logic req_s1_q, req_s2_q, req_s3_q;
  logic take;

  // ---------------------------------------------------------------
  // Source side
  // ---------------------------------------------------------------
  assign src_busy = req_q ^ ack_s2_q;
  assign take = src_valid && !src_busy;

  // Data held stable while the toggle is in flight
  always_ff @(posedge src_clk or negedge src_rst_n)
    if (!src_rst_n)
    begin
      req_q <= 1'b0;
      hold_q <= '0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end
    else
    begin
      req_q <= req_q ^ take;
      hold_q <= take ? src_data : hold_q;
      ack_s1_q <= req_s3_q;
      ack_s2_q <= ack_s1_q;
    end

  // ---------------------------------------------------------------
  // Destination side
  // ---------------------------------------------------------------
  always_ff @(posedge dst_clk or negedge dst_rst_n)
    if (!dst_rst_n)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      dst_valid <= 1'b0;
      dst_data <= '0;
    end
    else
    begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      dst_valid <= req_s2_q ^ req_s3_q;
      dst_data <= (req_s2_q ^ req_s3_q) ? hold_q : dst_data;
    end
endmodule

// [hw/hotswap_monitor_register_bank.sv]
// Register bank and bus-address decode of a switch controller with monitoring.
// Assumes a byte-level bus front end on LINK_CLK and analog/ADC logic on CLK.
module hotswap_monitor_register_bank
  import hotswap_monitor_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = 100
)(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic LINK_CLK,
  input wire logic LINK_START,
  input wire logic LINK_STOP,
  input wire logic LINK_BYTE_VALID,
  input wire logic [7:0] LINK_BYTE,
  output logic LINK_ACK,
  input wire logic LINK_RD_REQ,
  output logic LINK_RD_VALID,
  output logic [7:0] LINK_RD_DATA,
  input wire logic [5:0] ADDR_STRAP,
  input wire logic ON_PIN,
  input wire logic [5:0] COND_IN,
  input wire logic [5:0] FAULT_EVENT,
  input wire logic ADC_VALID,
  input wire logic [7:0] ADC_SENSE,
  input wire logic [7:0] ADC_SOURCE,
  input wire logic [7:0] ADC_AUX,
  input wire logic GPIO_IN,
  output logic GPIO_OUT,
  output logic GPIO_OE_N,
  output logic ALERT_OUT,
  output logic ALERT_OE_N,
  output logic SWITCH_ON,
  output logic OC_RETRY_EN,
  output logic UV_RETRY_EN,
  output logic OV_RETRY_EN,
  output logic ADC_HALT
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam logic [15:0] DEB_CNT = 16'(DEBOUNCE_CYCLES);
  // Core domain
  logic [7:0] ctrl_q, alert_en_q, fault_q;
  logic [7:0] adc_q [NUM_ADC];
  logic [7:0] adc_in [NUM_ADC];
  logic [NUM_ADC-1:0] wr_adc;
  logic [4:0] strap_q;
  logic [15:0] deb_cnt_q;
  logic sw_written_q, alert_q, gpio_out_q, gpio_oe_n_q;
  logic [5:0] strap_s1_q, strap_s2_q, cond_s1_q, cond_s2_q;
  logic on_s1_q, on_s2_q, gpio_s1_q, gpio_s2_q;
  logic wr_valid, rdreq_valid, rdans_busy;
  logic [10:0] wr_word;
  logic [2:0] rdreq_idx;
  logic [7:0] rd_mux, status_w, fault_d, wr_dat;
  logic [2:0] wr_idx;
  logic wr_ctrl, wr_alert, wr_fault, test_mode, deb_hit, gpio_lvl, gpio_oe_n_d;
  logic [1:0] pin_fn;
  // Link domain
  link_state_t state_q, state_d;
  logic [2:0] ptr_q;
  logic [4:0] strap_l1_q, strap_l2_q;
  logic bcast_l1_q, bcast_l2_q, alert_l1_q, alert_l2_q;
  logic [6:0] own_addr, byte_addr;
  logic byte_rw, hit_own, hit_bcast, hit_ara, ack_w;
  logic send_wr, send_rdreq, local_rd, rdans_valid, wr_busy, rdreq_busy;
  logic [7:0] rdans_data, rd_data_q;
  logic rd_valid_q;

  // ---------------------------------------------------------------
  // Core-side pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      strap_s1_q <= '0;
      strap_s2_q <= '0;
      cond_s1_q <= '0;
      cond_s2_q <= '0;
      {on_s1_q, on_s2_q, gpio_s1_q, gpio_s2_q} <= '0;
    end
    else
    begin
      strap_s1_q <= ADDR_STRAP;
      strap_s2_q <= strap_s1_q;
      cond_s1_q <= COND_IN;
      cond_s2_q <= cond_s1_q;
      {on_s1_q, on_s2_q} <= {ON_PIN, on_s1_q};
      {gpio_s1_q, gpio_s2_q} <= {GPIO_IN, gpio_s1_q};
    end

  // ---------------------------------------------------------------
  // Post-reset sequencing: strap capture and switch seeding
  // ---------------------------------------------------------------
  // One counter serves both; the strap is caught once the synchroniser is full
  assign deb_hit = (deb_cnt_q == DEB_CNT);

  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      deb_cnt_q <= '0;
      strap_q <= '0;
    end
    else
    begin
      deb_cnt_q <= (deb_cnt_q == 16'hffff) ? deb_cnt_q : deb_cnt_q + 16'h1;
      if (deb_cnt_q == 16'(STRAP_SETTLE))
        strap_q <= strap_decode(strap_s2_q);
    end

  // ---------------------------------------------------------------
  // Register write decode
  // ---------------------------------------------------------------
  assign wr_idx = wr_word[10:8];
  assign wr_dat = wr_word[7:0];
  assign test_mode = ctrl_q[TEST_MODE_POS];
  assign wr_ctrl = wr_valid && (wr_idx == IDX_CTRL);
  assign wr_alert = wr_valid && (wr_idx == IDX_ALERT);
  assign wr_fault = wr_valid && (wr_idx == IDX_FAULT);
  // Result writes land only while test mode holds
  assign wr_adc[0] = wr_valid && test_mode && (wr_idx == IDX_SENSE);
  assign wr_adc[1] = wr_valid && test_mode && (wr_idx == IDX_SOURCE);
  assign wr_adc[2] = wr_valid && test_mode &&
                     ((wr_idx == IDX_AUX) || (wr_idx == IDX_AUX_ALIAS));
  // A new event in the clearing cycle survives the write
  assign fault_d = ((wr_fault ? wr_dat : fault_q) | {2'h0, FAULT_EVENT}) & FAULT_MASK;

  // Control, alert-enable and fault registers
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      ctrl_q <= CTRL_RESET;
      alert_en_q <= ALERT_RESET;
      fault_q <= '0;
      sw_written_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= wr_ctrl ? wr_dat : ctrl_q;
      if (deb_hit && !wr_ctrl && !sw_written_q)
        ctrl_q[SWITCH_ON_POS] <= on_s2_q;
      sw_written_q <= sw_written_q | wr_ctrl;
      alert_en_q <= wr_alert ? (wr_dat & ALERT_MASK) : alert_en_q;
      fault_q <= fault_d;
    end

  // ---------------------------------------------------------------
  // Conversion result registers
  // ---------------------------------------------------------------
  assign adc_in[0] = ADC_SENSE;
  assign adc_in[1] = ADC_SOURCE;
  assign adc_in[2] = ADC_AUX;

  // Converter updates stop in test mode so host-written values stick
  for (genvar i = 0; i < NUM_ADC; i++)
  begin : g_adc
    always_ff @(posedge CLK or negedge NRST)
      if (!NRST)
        adc_q[i] <= ADC_RESET;
      else if (wr_adc[i])
        adc_q[i] <= wr_dat;
      else if (ADC_VALID && !test_mode)
        adc_q[i] <= adc_in[i];
  end

  // ---------------------------------------------------------------
  // Read mux, answered back to the link domain
  // ---------------------------------------------------------------
  assign status_w = {ctrl_q[SWITCH_ON_POS], gpio_s2_q, cond_s2_q};
  assign rd_mux = (rdreq_idx == IDX_CTRL) ? ctrl_q :
                  (rdreq_idx == IDX_ALERT) ? alert_en_q :
                  (rdreq_idx == IDX_STATUS) ? status_w :
                  (rdreq_idx == IDX_FAULT) ? fault_q :
                  (rdreq_idx == IDX_SENSE) ? adc_q[0] :
                  (rdreq_idx == IDX_SOURCE) ? adc_q[1] :
                  adc_q[2];

  // ---------------------------------------------------------------
  // Pins: general pin, alert, switch and retry enables
  // ---------------------------------------------------------------
  assign pin_fn = {ctrl_q[PIN_FN_HI], ctrl_q[PIN_FN_LO]};
  assign gpio_lvl = (pin_fn == FN_PWR_GOOD) ? !cond_s2_q[PWR_BAD_POS] :
                    (pin_fn == FN_PWR_BAD) ? cond_s2_q[PWR_BAD_POS] :
                    alert_en_q[PIN_DATA_POS];
  // Both function bits set leaves the pin as an input
  assign gpio_oe_n_d = (pin_fn == (FN_PWR_BAD | FN_OUTPUT));

  // Registered so the pins never glitch on a mux change
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      gpio_out_q <= 1'b0;
      gpio_oe_n_q <= 1'b1;
      alert_q <= 1'b0;
    end
    else
    begin
      gpio_out_q <= gpio_lvl;
      gpio_oe_n_q <= gpio_oe_n_d;
      alert_q <= |(fault_q[NUM_FAULT-1:0] & alert_en_q[NUM_FAULT-1:0]);
    end

  assign GPIO_OUT = gpio_out_q;
  assign GPIO_OE_N = gpio_oe_n_q;
  assign ALERT_OUT = 1'b0;
  assign ALERT_OE_N = !alert_q;
  assign SWITCH_ON = ctrl_q[SWITCH_ON_POS];
  assign OC_RETRY_EN = ctrl_q[OC_RETRY_POS];
  assign UV_RETRY_EN = ctrl_q[UV_RETRY_POS];
  assign OV_RETRY_EN = ctrl_q[OV_RETRY_POS];
  assign ADC_HALT = test_mode;

  // ---------------------------------------------------------------
  // Clock crossings
  // ---------------------------------------------------------------
  // Writes and read requests go link to core, read answers come back
  cdc_word_handshake #(.W(11)) u_wr (
    .src_clk(LINK_CLK),
    .src_rst_n(NRST),
    .src_valid(send_wr),
    .src_data({ptr_q, LINK_BYTE}),
    .src_busy(wr_busy),
    .dst_clk(CLK),
    .dst_rst_n(NRST),
    .dst_valid(wr_valid),
    .dst_data(wr_word)
  );

  cdc_word_handshake #(.W(3)) u_rdreq (
    .src_clk(LINK_CLK),
    .src_rst_n(NRST),
    .src_valid(send_rdreq),
    .src_data(ptr_q),
    .src_busy(rdreq_busy),
    .dst_clk(CLK),
    .dst_rst_n(NRST),
    .dst_valid(rdreq_valid),
    .dst_data(rdreq_idx)
  );

  cdc_word_handshake #(.W(8)) u_rdans (
    .src_clk(CLK),
    .src_rst_n(NRST),
    .src_valid(rdreq_valid),
    .src_data(rd_mux),
    .src_busy(rdans_busy),
    .dst_clk(LINK_CLK),
    .dst_rst_n(NRST),
    .dst_valid(rdans_valid),
    .dst_data(rdans_data)
  );

  // Quasi-static levels into the link domain; the strap word only
  // changes once after reset, long before any bus traffic
  always_ff @(posedge LINK_CLK or negedge NRST)
    if (!NRST)
    begin
      strap_l1_q <= '0;
      strap_l2_q <= '0;
      {bcast_l1_q, bcast_l2_q, alert_l1_q, alert_l2_q} <= '0;
    end
    else
    begin
      strap_l1_q <= strap_q;
      strap_l2_q <= strap_l1_q;
      {bcast_l1_q, bcast_l2_q} <= {ctrl_q[BCAST_EN_POS], bcast_l1_q};
      {alert_l1_q, alert_l2_q} <= {alert_q, alert_l1_q};
    end

  // ---------------------------------------------------------------
  // Link side: address match and transaction sequence
  // ---------------------------------------------------------------
  assign own_addr = {ADDR_FIXED, strap_l2_q};
  assign byte_addr = LINK_BYTE[7:1];
  assign byte_rw = LINK_BYTE[0];
  assign hit_own = (byte_addr == own_addr);
  assign hit_bcast = (byte_addr == BCAST_ADDR) && !byte_rw && bcast_l2_q;
  assign hit_ara = (byte_addr == ARA_ADDR) && byte_rw && alert_l2_q;

  // Acknowledge decision for the byte on LINK_BYTE
  always_comb
  begin
    case (state_q)
      L_ADDR: ack_w = hit_own || hit_bcast || hit_ara;
      L_CMD: ack_w = 1'b1;
      L_DATA: ack_w = 1'b1;
      L_DISCARD: ack_w = 1'b1;
      default: ack_w = 1'b0;
    endcase
  end

  assign LINK_ACK = LINK_BYTE_VALID && ack_w;

  // Next state; a start or stop overrides any byte
  always_comb
  begin
    state_d = state_q;
    if (LINK_START)
      state_d = L_ADDR;
    else if (LINK_STOP)
      state_d = L_IDLE;
    else if (LINK_BYTE_VALID)
    begin
      case (state_q)
        L_ADDR:
        begin
          if (hit_own)
            state_d = byte_rw ? L_READ : L_CMD;
          else if (hit_bcast)
            state_d = L_CMD;
          else if (hit_ara)
            state_d = L_ARA;
          else
            state_d = L_NOMATCH;
        end
        L_CMD: state_d = L_DATA;
        L_DATA: state_d = L_DISCARD;
        default: state_d = state_q;
      endcase
    end
  end

  assign send_wr = LINK_BYTE_VALID && !LINK_START && !LINK_STOP && (state_q == L_DATA);
  assign send_rdreq = LINK_RD_REQ && (state_q == L_READ);
  // Alert response answers with this device's own address
  assign local_rd = LINK_RD_REQ && (state_q == L_ARA);

  // Pointer survives the stop, so a bare read repeats the last register
  always_ff @(posedge LINK_CLK or negedge NRST)
    if (!NRST)
    begin
      state_q <= L_IDLE;
      ptr_q <= IDX_CTRL;
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (LINK_BYTE_VALID && !LINK_START && !LINK_STOP && (state_q == L_CMD))
        ptr_q <= LINK_BYTE[IDX_W-1:0];
      rd_valid_q <= rdans_valid || local_rd;
      if (local_rd)
        rd_data_q <= {own_addr, 1'b0};
      else if (rdans_valid)
        rd_data_q <= rdans_data;
    end

  assign LINK_RD_VALID = rd_valid_q;
  assign LINK_RD_DATA = rd_data_q;
endmodule

// [verif/hotswap_host_model.sv]
// Host master model: byte-level start, stop, data and read requests on the link.
// Assumes the bank answers ack in the byte cycle and read data within 40 link cycles.
module hotswap_host_model (
  input wire logic link_clk,
  input wire logic ack,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic start,
  output logic stop,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic rd_req
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle levels from time zero
  initial
  begin
    start = 1'b0;
    stop = 1'b0;
    byte_valid = 1'b0;
    byte_data = 8'h00;
    rd_req = 1'b0;
  end
  // Request spacing; the bank drops closer requests
  task automatic gap();
    repeat (30) @(posedge link_clk);
  endtask
  // Start or stop condition, one cycle wide
  task automatic cond(input logic is_stop);
    @(posedge link_clk);
    start <= ~is_stop;
    stop <= is_stop;
    @(posedge link_clk);
    start <= 1'b0;
    stop <= 1'b0;
    gap();
  endtask
  // One byte; ack taken at the edge ending it
  task automatic send(input logic [7:0] b, output logic a);
    @(posedge link_clk);
    byte_valid <= 1'b1;
    byte_data <= b;
    @(posedge link_clk);
    a = ack;
    byte_valid <= 1'b0;
    byte_data <= ~b; // Released data never holds
    gap();
  endtask
  // One read byte; unknown if no answer comes
  task automatic read(output logic [7:0] d);
    @(posedge link_clk);
    rd_req <= 1'b1;
    @(posedge link_clk);
    rd_req <= 1'b0;
    d = 8'hxx;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge link_clk);
      if (rd_valid === 1'b1)
      begin
        d = rd_data;
        break;
      end
    end
    gap();
  endtask
endmodule

// [verif/hotswap_monitor_register_bank_sva.sv]
// Checker for the register bank: link handshake, reset values, address filter.
// Assumes it is bound to the bank's top module and sees its ports only.
module hotswap_monitor_checker
  import hotswap_monitor_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic LINK_CLK,
  input wire logic LINK_START,
  input wire logic LINK_BYTE_VALID,
  input wire logic [7:0] LINK_BYTE,
  input wire logic LINK_ACK,
  input wire logic LINK_RD_REQ,
  input wire logic LINK_RD_VALID,
  input wire logic [7:0] LINK_RD_DATA,
  input wire logic ALERT_OUT,
  input wire logic ALERT_OE_N,
  input wire logic SWITCH_ON,
  input wire logic OC_RETRY_EN,
  input wire logic UV_RETRY_EN,
  input wire logic OV_RETRY_EN,
  input wire logic ADC_HALT
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Address phase: first byte after any start condition
  // ---------------------------------------------------------------
  logic addr_ph_q, addr_ph_d;
  assign addr_ph_d = LINK_START | (addr_ph_q & ~LINK_BYTE_VALID);
  // Tracks the phase on the link clock
  always_ff @(posedge LINK_CLK or negedge NRST)
    if (!NRST)
      addr_ph_q <= 1'b0;
    else
      addr_ph_q <= addr_ph_d;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_rst_vals;
    @(posedge CLK) disable iff (!NRST)
    $rose(NRST) |-> !SWITCH_ON && !OC_RETRY_EN && UV_RETRY_EN && OV_RETRY_EN && !ADC_HALT;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("control outputs wrong after reset");
  property p_alert_low;
    @(posedge CLK) disable iff (!NRST) ALERT_OUT == 1'b0;
  endproperty
  a_alert_low: assert property (p_alert_low)
    else $error("alert pin driven high");
  property p_ack_byte;
    @(posedge LINK_CLK) disable iff (!NRST) LINK_ACK |-> LINK_BYTE_VALID;
  endproperty
  a_ack_byte: assert property (p_ack_byte)
    else $error("ack outside a byte cycle");
  property p_rd_answer;
    @(posedge LINK_CLK) disable iff (!NRST) LINK_RD_REQ |-> ##[1:24] LINK_RD_VALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read request not answered");
  property p_rd_pulse;
    @(posedge LINK_CLK) disable iff (!NRST) LINK_RD_VALID |=> !LINK_RD_VALID;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read valid longer than one cycle");
  property p_rd_hold;
    @(posedge LINK_CLK) disable iff (!NRST) !LINK_RD_VALID |-> $stable(LINK_RD_DATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without valid");
  property p_ara_ack;
    @(posedge LINK_CLK) disable iff (!NRST)
    addr_ph_q && LINK_BYTE_VALID && LINK_BYTE == {ARA_ADDR, 1'b1} && LINK_ACK |-> !ALERT_OE_N;
  endproperty
  a_ara_ack: assert property (p_ara_ack)
    else $error("alert response acked while not alerting");
  property p_addr_fixed;
    @(posedge LINK_CLK) disable iff (!NRST)
    addr_ph_q && LINK_BYTE_VALID && LINK_BYTE[7:6] != 2'h2 && LINK_BYTE[7:1] != ARA_ADDR
      |-> !LINK_ACK;
  endproperty
  a_addr_fixed: assert property (p_addr_fixed)
    else $error("address with wrong top bits acked");
  property p_bcast_read;
    @(posedge LINK_CLK) disable iff (!NRST)
    addr_ph_q && LINK_BYTE_VALID && LINK_BYTE == {BCAST_ADDR, 1'b1} |-> !LINK_ACK;
  endproperty
  a_bcast_read: assert property (p_bcast_read)
    else $error("broadcast read acked");
endmodule
bind hotswap_monitor_register_bank hotswap_monitor_checker hotswap_monitor_checker_inst (
  .CLK, .NRST, .LINK_CLK, .LINK_START, .LINK_BYTE_VALID, .LINK_BYTE, .LINK_ACK, .LINK_RD_REQ,
  .LINK_RD_VALID, .LINK_RD_DATA, .ALERT_OUT, .ALERT_OE_N, .SWITCH_ON, .OC_RETRY_EN,
  .UV_RETRY_EN, .OV_RETRY_EN, .ADC_HALT);

// [verif/hotswap_monitor_register_bank_tb.sv]
// Self-checking bench for the monitor register bank through a host model.
// Assumes package, host model and checker are compiled before this file.
module hotswap_monitor_register_bank_tb;
  import hotswap_monitor_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK, NRST, LINK_CLK, LINK_START, LINK_STOP, LINK_BYTE_VALID, LINK_ACK;
  logic LINK_RD_REQ, LINK_RD_VALID, ON_PIN, ADC_VALID, GPIO_IN, GPIO_OUT, GPIO_OE_N;
  logic ALERT_OUT, ALERT_OE_N, SWITCH_ON, OC_RETRY_EN, UV_RETRY_EN, OV_RETRY_EN, ADC_HALT;
  logic [7:0] LINK_BYTE, LINK_RD_DATA, ADC_SENSE, ADC_SOURCE, ADC_AUX;
  logic [5:0] ADDR_STRAP, COND_IN, FAULT_EVENT;
  logic [6:0] own;
  int failures, samples_checked;
  // Rows: write cmd, write data, read cmd, expected read
  logic [31:0] rows [10] = '{32'h01ff017f, 32'h09000100, 32'h045a043c, 32'h002c002c,
    32'h045afc5a, 32'h05a605a6, 32'h07710671, 32'h06180718, 32'h03ff033f, 32'h02ff02d5};
  logic [7:0] gpio_exp [4] = '{8'h1c, 8'h5c, 8'h5c, 8'h9c};
  // Clocks with unrelated phase
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial
  begin
    LINK_CLK = 1'b0;
    #2.3;
    forever #3 LINK_CLK = ~LINK_CLK;
  end
  // Board pull-up on the released pin
  assign GPIO_IN = GPIO_OE_N ? 1'b1 : GPIO_OUT;
  // Converter results every other cycle
  always @(posedge CLK) ADC_VALID <= (ADC_VALID !== 1'b1);
  hotswap_monitor_register_bank #(.DEBOUNCE_CYCLES(20)) hotswap_monitor_register_bank_inst (
    .CLK, .NRST, .LINK_CLK, .LINK_START, .LINK_STOP, .LINK_BYTE_VALID, .LINK_BYTE, .LINK_ACK,
    .LINK_RD_REQ, .LINK_RD_VALID, .LINK_RD_DATA, .ADDR_STRAP, .ON_PIN, .COND_IN, .FAULT_EVENT,
    .ADC_VALID, .ADC_SENSE, .ADC_SOURCE, .ADC_AUX, .GPIO_IN, .GPIO_OUT, .GPIO_OE_N, .ALERT_OUT,
    .ALERT_OE_N, .SWITCH_ON, .OC_RETRY_EN, .UV_RETRY_EN, .OV_RETRY_EN, .ADC_HALT);
  hotswap_host_model host (
    .link_clk(LINK_CLK), .ack(LINK_ACK), .rd_valid(LINK_RD_VALID), .rd_data(LINK_RD_DATA),
    .start(LINK_START), .stop(LINK_STOP), .byte_valid(LINK_BYTE_VALID),
    .byte_data(LINK_BYTE), .rd_req(LINK_RD_REQ));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] outs();
    outs = {GPIO_OE_N, GPIO_OUT, 1'b0, SWITCH_ON, ADC_HALT, OC_RETRY_EN, UV_RETRY_EN,
      OV_RETRY_EN};
  endfunction
  task automatic reset_dut();
    @(posedge CLK) NRST <= 1'b0;
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    repeat (40) @(posedge CLK);
  endtask
  // Write one register; word adds a discarded byte
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input logic word);
    logic a0, a1, a2, a3;
    host.cond(1'b0);
    host.send({own, 1'b0}, a0);
    host.send(cmd, a1);
    host.send(d, a2);
    a3 = 1'b1;
    if (word)
      host.send(8'h3f, a3);
    host.cond(1'b1);
    chk({7'h0, a0 & a1 & a2 & a3}, 8'h01);
    repeat (20) @(posedge CLK);
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [7:0] d);
    logic a;
    host.cond(1'b0);
    host.send({own, 1'b0}, a);
    host.send(cmd, a);
    host.cond(1'b0);
    host.send({own, 1'b1}, a);
    host.read(d);
    host.cond(1'b1);
  endtask
  // Address byte alone; an acked read fetches a byte
  task automatic probe(input logic [7:0] b, input logic [7:0] ea, input logic [7:0] ed);
    logic a;
    logic [7:0] d;
    host.cond(1'b0);
    host.send(b, a);
    chk({7'h0, a}, ea);
    if (a === 1'b1 && b[0])
    begin
      host.read(d);
      chk(d, ed);
    end
    host.cond(1'b1);
  endtask
  task automatic test_done();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog well beyond the expected 50 us of traffic
  initial
  begin
    #400000;
    failures++;
    test_done();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    NRST = 1'b0;
    ON_PIN = 1'b0;
    COND_IN = 6'h15;
    FAULT_EVENT = 6'h00;
    ADC_SENSE = 8'h3c;
    ADC_SOURCE = 8'h96;
    ADC_AUX = 8'h2d;
    ADDR_STRAP = 6'h00;
    own = 7'h44;
    failures = 0;
    samples_checked = 0;
    reset_dut();
    chk(outs(), 8'h43);
    for (int i = 0; i < 10; i++)
    begin
      wr(rows[i][31:24], rows[i][23:16], 1'b0);
      rd(rows[i][15:8], d);
      chk(d, rows[i][7:0]);
    end
    chk(outs(), 8'h5c);
    {ADC_SENSE, ADC_SOURCE, ADC_AUX} <= 24'hc369d2;
    rd(8'h04, d);
    chk(d, 8'h5a);
    probe(8'hbe, 8'h00, 8'h00);
    probe(8'hbf, 8'h00, 8'h00);
    probe(8'h8c, 8'h00, 8'h00);
    probe(8'h48, 8'h00, 8'h00);
    wr(8'h01, 8'h40, 1'b1);
    rd(8'h01, d);
    chk(d, 8'h40);
    @(posedge CLK) COND_IN <= 6'h08;
    for (int fn = 0; fn < 4; fn++)
    begin
      wr(8'h00, {2'(fn), 6'h2c}, 1'b0);
      chk(outs() & ((fn == 3) ? 8'hbf : 8'hff), gpio_exp[fn]);
    end
    probe(8'h19, 8'h00, 8'h00);
    wr(8'h03, 8'h00, 1'b0);
    wr(8'h01, 8'h01, 1'b0);
    chk({7'h0, ALERT_OE_N}, 8'h01);
    @(posedge CLK) FAULT_EVENT <= 6'h01;
    @(posedge CLK) FAULT_EVENT <= 6'h00;
    repeat (4) @(posedge CLK);
    chk({7'h0, ALERT_OE_N}, 8'h00);
    probe(8'h19, 8'h01, {own, 1'b0});
    ADDR_STRAP <= 6'h2a;
    ON_PIN <= 1'b1;
    own = 7'h4a;
    reset_dut();
    chk(outs(), 8'h13);
    probe(8'h88, 8'h00, 8'h00);
    probe(8'hbe, 8'h01, 8'h00);
    rd(8'h00, d);
    chk(d, 8'h1b);
    rd(8'h01, d);
    chk(d, 8'h00);
    rd(8'h05, d);
    chk(d, 8'h69);
    own = 7'h5f;
    wr(8'h01, 8'h25, 1'b0);
    own = 7'h4a;
    rd(8'h01, d);
    chk(d, 8'h25);
    test_done();
  end
endmodule
